// *** rtl/snfe_front_end.v ***
`timescale 1ns/10ps
`default_nettype none
`include "snfe_defines.vh"
module snfe_front_end (
  input  wire        mclk_i,          // System clock, 125 MHz
  input  wire        sys_rst_i,       // Synchronous reset, active high
  input  wire        sclk_i,          // Serial clock pin
  input  wire        cs_n_i,          // Chip select, active low
  input  wire [3:0]  io_i,            // io3..io0 pin levels
  output reg  [3:0]  io_o,            // io3..io0 drive values
  output reg  [3:0]  io_oe_o,         // io3..io0 drive enables
  input  wire [7:0]  status_i,        // Status byte from core (write_latch slot ignored)
  input  wire [7:0]  cache_data_i,    // Cache byte at cache_col_o
  output reg  [11:0] cache_col_o,     // Current cache column
  output reg  [7:0]  opcode_o,        // Last opcode taken
  output reg  [15:0] row_addr_o,      // Block and page address
  output reg         array_cmd_o,     // Pulse: array command framed
  output reg  [7:0]  load_data_o,     // Program load byte
  output reg         load_strobe_o,   // Pulse: load byte valid
  output reg         write_latch_o,   // Write enable latch
  output wire        quad_enable_o,   // Quad enable feature bit
  output wire        paused_o,        // Pause active
  output reg         reject_o         // Pulse: quad command refused
);
  // ==========================================
  // Pin synchronisation
  wire [5:0] syn;
  snfe_sync #(.W(6)) u_sync (
    .mclk_i (mclk_i),
    .d_i    ({sclk_i, cs_n_i, io_i}),
    .q_o    (syn)
  );
  wire sck   = syn[5];
  wire csn   = syn[4];
  wire [3:0] pin = syn[3:0];

  reg       sck_d_reg;
  reg       csn_d_reg;
  reg       armed_reg;
  reg       paused_reg;
  reg       pause_pend_reg;
  reg [7:0] lock_reg;
  reg [7:0] feat_reg;
  reg [7:0] drv_reg;

  wire qe      = feat_reg[`SNFE_QE_BIT];
  wire hold_n  = pin[3];
  wire sel     = !csn && armed_reg;
  wire rise    = sck && !sck_d_reg && sel && !paused_reg;
  wire fall    = !sck && sck_d_reg && sel && !paused_reg;
  assign quad_enable_o = qe;
  assign paused_o      = paused_reg;

  // ==========================================
  // Select tracking and pause control
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sck_d_reg      <= 1'b0;
      // Select low at reset is not a fall
      csn_d_reg      <= 1'b0;
      armed_reg      <= 1'b0;
      paused_reg     <= 1'b0;
      pause_pend_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck;
      csn_d_reg <= csn;
      if (!csn && csn_d_reg)
        armed_reg <= 1'b1;
      if (csn || qe) begin
        paused_reg     <= 1'b0;
        pause_pend_reg <= 1'b0;
      end else if (sel) begin
        if (!sck && !sck_d_reg)
          paused_reg <= !hold_n;
        else if (!sck && sck_d_reg)
          paused_reg <= !hold_n;
      end
    end
  end

  // ==========================================
  // Command sequencer
  localparam ST_OP    = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_OUT   = 3'h3;
  localparam ST_IN    = 3'h4;
  localparam ST_DONE  = 3'h5;

  reg [2:0]  st_reg;
  reg [7:0]  op_reg;
  reg [7:0]  sh_reg;
  reg [3:0]  bit_reg;
  reg [1:0]  nadr_reg;
  reg [1:0]  aidx_reg;
  reg [23:0] adr_reg;
  reg [1:0]  wid_reg;      // 0 single, 1 dual, 2 quad
  reg [1:0]  awid_reg;
  reg [3:0]  dum_reg;
  reg        src_id_reg;
  reg        src_feat_reg;
  reg [7:0]  out_reg;
  reg        out_first_reg;

  // Bits per clock
  function [3:0] step;
    input [1:0] w;
    begin
      step = (w == 2'd2) ? 4'd4 : (w == 2'd1) ? 4'd2 : 4'd1;
    end
  endfunction

  // Sample bus lanes into shifter, MSB first
  function [7:0] shin;
    input [7:0] s;
    input [1:0] w;
    input [3:0] p;
    begin
      case (w)
        2'd2:    shin = {s[3:0], p};
        2'd1:    shin = {s[5:0], p[1:0]};
        default: shin = {s[6:0], p[0]};
      endcase
    end
  endfunction

  wire [7:0] nsh  = shin(sh_reg, (st_reg == ST_OP) ? 2'd0 :
                         (st_reg == ST_ADDR) ? awid_reg : wid_reg, pin);
  wire [3:0] nbit = bit_reg + step((st_reg == ST_OP) ? 2'd0 :
                         (st_reg == ST_ADDR) ? awid_reg : wid_reg);
  wire       byte_done = (nbit == 4'd8);
  wire [7:0] feat_rd = (adr_reg[7:0] == `SNFE_FA_LOCK) ? lock_reg :
                       (adr_reg[7:0] == `SNFE_FA_FEAT) ? feat_reg :
                       (adr_reg[7:0] == `SNFE_FA_STAT) ? {status_i[7:2], write_latch_o, status_i[0]} :
                       (adr_reg[7:0] == `SNFE_FA_DRV)  ? drv_reg : 8'h00;
  wire [7:0] out_src = src_id_reg ? (out_first_reg ? `SNFE_MAKER_ID : `SNFE_PART_ID) :
                       src_feat_reg ? feat_rd : cache_data_i;
  // Lock guard, void under quad enable
  wire guard = lock_reg[`SNFE_GUARD_BIT] && !pin[2] && !qe;
  wire is_q  = (nsh == `SNFE_OP_RC4) || (nsh == `SNFE_OP_RCQ) || (nsh == `SNFE_OP_PL4) ||
               (nsh == `SNFE_OP_PLR4A) || (nsh == `SNFE_OP_PLR4B) || (nsh == `SNFE_OP_PLRQ);

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg        <= ST_OP;
      op_reg        <= 8'h00;
      sh_reg        <= 8'h00;
      bit_reg       <= 4'h0;
      nadr_reg      <= 2'd0;
      aidx_reg      <= 2'd0;
      adr_reg       <= 24'h000000;
      wid_reg       <= 2'd0;
      awid_reg      <= 2'd0;
      dum_reg       <= 4'h0;
      src_id_reg    <= 1'b0;
      src_feat_reg  <= 1'b0;
      out_reg       <= 8'h00;
      out_first_reg <= 1'b0;
      io_o          <= 4'h0;
      io_oe_o       <= 4'h0;
      lock_reg      <= `SNFE_LOCK_RST;
      feat_reg      <= `SNFE_FEAT_RST;
      drv_reg       <= `SNFE_DRV_RST;
      write_latch_o <= 1'b0;
      cache_col_o   <= 12'h000;
      opcode_o      <= 8'h00;
      row_addr_o    <= 16'h0000;
      array_cmd_o   <= 1'b0;
      load_data_o   <= 8'h00;
      load_strobe_o <= 1'b0;
      reject_o      <= 1'b0;
    end else begin
      array_cmd_o   <= 1'b0;
      load_strobe_o <= 1'b0;
      reject_o      <= 1'b0;
      if (!sel) begin
        st_reg  <= ST_OP;
        bit_reg <= 4'h0;
        io_oe_o <= 4'h0;
      end else if (paused_reg) begin
        io_oe_o <= 4'h0;
      end else if (rise) begin
        if (st_reg != ST_OUT) begin                // Output phase counts on falls
          sh_reg  <= byte_done ? 8'h00 : nsh;
          bit_reg <= byte_done ? 4'h0 : nbit;
        end
        case (st_reg)
          ST_OP: if (byte_done) begin
            op_reg   <= nsh;
            opcode_o <= nsh;
            aidx_reg <= 2'd0;
            adr_reg  <= 24'h000000;
            src_id_reg   <= (nsh == `SNFE_OP_RDID);
            src_feat_reg <= (nsh == `SNFE_OP_GETF);
            wid_reg  <= 2'd0;
            awid_reg <= 2'd0;
            dum_reg  <= 4'h0;
            // Two column bytes unless the opcode says otherwise
            nadr_reg <= 2'd1;
            st_reg   <= ST_ADDR;
            if (is_q && !qe) begin
              reject_o <= 1'b1;
              st_reg   <= ST_DONE;
            end else case (nsh)
              `SNFE_OP_WREN: begin
                write_latch_o <= 1'b1;
                st_reg <= ST_DONE;
              end
              `SNFE_OP_WRDI: begin
                write_latch_o <= 1'b0;
                st_reg <= ST_DONE;
              end
              `SNFE_OP_GETF, `SNFE_OP_SETF, `SNFE_OP_RDID: nadr_reg <= 2'd0;
              `SNFE_OP_PRD, `SNFE_OP_PE, `SNFE_OP_BE: nadr_reg <= 2'd2;
              `SNFE_OP_RC1, `SNFE_OP_RC1F: dum_reg <= `SNFE_DUM_CLK1;
              `SNFE_OP_RC2: begin
                wid_reg <= 2'd1;
                dum_reg <= `SNFE_DUM_CLK1;
              end
              `SNFE_OP_RC4: begin
                wid_reg <= 2'd2;
                dum_reg <= `SNFE_DUM_CLK1;
              end
              `SNFE_OP_RCD: begin
                wid_reg  <= 2'd1;
                awid_reg <= 2'd1;
                dum_reg  <= `SNFE_DUM_CLK2;
              end
              `SNFE_OP_RCQ: begin
                wid_reg  <= 2'd2;
                awid_reg <= 2'd2;
                dum_reg  <= `SNFE_DUM_CLK4;
              end
              `SNFE_OP_PL4, `SNFE_OP_PLR4A, `SNFE_OP_PLR4B: wid_reg <= 2'd2;
              `SNFE_OP_PLRQ: begin
                wid_reg  <= 2'd2;
                awid_reg <= 2'd2;
              end
              `SNFE_OP_PL, `SNFE_OP_PLR: wid_reg <= 2'd0;
              default: st_reg <= ST_DONE;
            endcase
          end
          ST_ADDR: if (byte_done) begin
            adr_reg  <= {adr_reg[15:0], nsh};
            aidx_reg <= aidx_reg + 2'd1;
            if (aidx_reg == nadr_reg) begin
              case (op_reg)
                `SNFE_OP_PRD, `SNFE_OP_PE, `SNFE_OP_BE: begin
                  row_addr_o  <= {adr_reg[7:0], nsh};
                  array_cmd_o <= 1'b1;
                  st_reg      <= ST_DONE;
                end
                `SNFE_OP_SETF: st_reg <= ST_IN;
                `SNFE_OP_GETF, `SNFE_OP_RDID: begin
                  st_reg        <= ST_OUT;
                  out_first_reg <= 1'b1;
                end
                default: begin
                  cache_col_o <= {adr_reg[3:0], nsh};
                  if (dum_reg != 4'h0)
                    st_reg <= ST_DUMMY;
                  else if (src_feat_reg || src_id_reg)
                    st_reg <= ST_OUT;
                  else begin
                    st_reg <= ((op_reg == `SNFE_OP_PL) || (op_reg == `SNFE_OP_PLR) ||
                               (op_reg == `SNFE_OP_PL4) || (op_reg == `SNFE_OP_PLR4A) ||
                               (op_reg == `SNFE_OP_PLR4B) || (op_reg == `SNFE_OP_PLRQ))
                              ? ST_IN : ST_OUT;
                  end
                end
              endcase
            end
          end
          // Dummy clocks are counted, their bits dropped
          ST_DUMMY: begin
            bit_reg <= 4'h0;
            dum_reg <= dum_reg - 4'd1;
            if (dum_reg == 4'd1) begin
              st_reg        <= ST_OUT;
              out_first_reg <= 1'b1;
            end
          end
          ST_IN: if (byte_done) begin
            if (op_reg == `SNFE_OP_SETF) begin
              st_reg <= ST_DONE;
              case (adr_reg[7:0])
                `SNFE_FA_LOCK: lock_reg <= guard ?
                  ((lock_reg & `SNFE_LOCK_WMASK) | (nsh & ~`SNFE_LOCK_WMASK & 8'h80)) :
                  (nsh & (`SNFE_LOCK_WMASK | 8'h80));
                `SNFE_FA_FEAT: feat_reg <= nsh & `SNFE_FEAT_WMASK;
                `SNFE_FA_DRV:  drv_reg  <= nsh & `SNFE_DRV_WMASK;
                default: ;
              endcase
            end else begin
              load_data_o   <= nsh;
              load_strobe_o <= 1'b1;
              cache_col_o   <= cache_col_o + 12'h001;
            end
          end
          default: ;
        endcase
      end else if (fall) begin
        if (st_reg == ST_OUT) begin
          if (out_first_reg || bit_reg == 4'h0) begin
            out_reg <= out_src << step(wid_reg);
            bit_reg <= step(wid_reg) & 4'h7;
            out_first_reg <= 1'b0;
            case (wid_reg)
              2'd2: begin
                io_o    <= out_src[7:4];
                io_oe_o <= 4'hF;
              end
              2'd1: begin
                io_o    <= {2'b00, out_src[7:6]};
                io_oe_o <= 4'h3;
              end
              default: begin
                io_o    <= {2'b00, out_src[7], 1'b0};
                io_oe_o <= 4'h2;
              end
            endcase
          end else begin
            out_reg <= out_reg << step(wid_reg);
            bit_reg <= (bit_reg + step(wid_reg)) & 4'h7;
            // Advance on the last bits so the next byte is fetched in time
            if ((((bit_reg + step(wid_reg)) & 4'h7) == 4'h0) && !src_feat_reg && !src_id_reg)
              cache_col_o <= cache_col_o + 12'h001;
            case (wid_reg)
              2'd2:    io_o <= out_reg[7:4];
              2'd1:    io_o <= {2'b00, out_reg[7:6]};
              default: io_o <= {2'b00, out_reg[7], 1'b0};
            endcase
          end
        end else begin
          io_oe_o <= 4'h0;
        end
      end
    end
  end
endmodule // snfe_front_end
`default_nettype wire

// *** rtl/snfe_sync.v ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-flop synchroniser, one per bit
module snfe_sync #(
  parameter W = 7
) (
  input  wire         mclk_i,   // System clock
  input  wire [W-1:0] d_i,      // Asynchronous inputs
  output wire [W-1:0] q_o       // Synchronised outputs
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge mclk_i) begin
        s1_reg[g] <= d_i[g];
        s2_reg[g] <= s1_reg[g];
      end
    end
  endgenerate
  assign q_o = s2_reg;
endmodule // snfe_sync
`default_nettype wire

// *** shared/snfe_defines.vh ***
// Operation
// - Inputs sampled on rising serial clock edges
// - Outputs change only after falling clock edges
// - Deselected device floats all four data pins
// - First select fall needed before commands
// - Dual commands use io0/io1, two bits
// - Quad commands use io0-io3; quad_enable first
// - Guard plus low protect pin locks protection
// - quad_enable disables write-protect pin function
// - Pause starts at pause_n fall, clock low
// - Pause ends at pause_n rise, clock low
// - Paused: output floats, input and clock ignored
// - Pause only without quad_enable
// - Get features; address C0h wraps status
// - Column bytes: four dummy, bits 11-8
// - BBh: dual address, dummy byte, dual data
// - EBh: quad address, dummy byte, quad data
// - 72h: quad address, data without dummy
// - 9Fh 00 returns maker then part code
// - Array commands take 24-bit address
// - 06h sets write_latch, 04h clears it
// - quad_enable is B0h bit 0
`ifndef SNFE_DEFINES_VH
`define SNFE_DEFINES_VH
`define SNFE_OP_WREN   8'h06
`define SNFE_OP_WRDI   8'h04
`define SNFE_OP_GETF   8'h0F
`define SNFE_OP_SETF   8'h1F
`define SNFE_OP_PRD    8'h13
`define SNFE_OP_RC1    8'h03
`define SNFE_OP_RC1F   8'h0B
`define SNFE_OP_RC2    8'h3B
`define SNFE_OP_RC4    8'h6B
`define SNFE_OP_RCD    8'hBB
`define SNFE_OP_RCQ    8'hEB
`define SNFE_OP_RDID   8'h9F
`define SNFE_OP_PL     8'h02
`define SNFE_OP_PL4    8'h32
`define SNFE_OP_PLR    8'h84
`define SNFE_OP_PLR4A  8'hC4
`define SNFE_OP_PLR4B  8'h34
`define SNFE_OP_PLRQ   8'h72
`define SNFE_OP_PE     8'h10
`define SNFE_OP_BE     8'hD8
`define SNFE_OP_RST    8'hFF
`define SNFE_FA_LOCK   8'hA0
`define SNFE_FA_FEAT   8'hB0
`define SNFE_FA_STAT   8'hC0
`define SNFE_FA_DRV    8'hD0
`define SNFE_QE_BIT    0
`define SNFE_LOCK_WMASK 8'h3E
`define SNFE_GUARD_BIT 7
`define SNFE_LOCK_RST  8'h00
`define SNFE_FEAT_RST  8'h00
`define SNFE_DRV_RST   8'h00
`define SNFE_FEAT_WMASK 8'h53
`define SNFE_DRV_WMASK 8'h60
`define SNFE_MAKER_ID  8'h5A
`define SNFE_PART_ID   8'hA5
`define SNFE_DUM_CLK1  4'h8
`define SNFE_DUM_CLK2  4'h4
`define SNFE_DUM_CLK4  4'h2
`endif

// *** tb/snfe_front_end_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "snfe_defines.vh"
module snfe_front_end_props (
  input wire logic       mclk_i,        // Clock
  input wire logic       sys_rst_i,     // Reset
  input wire logic       sclk_i,        // Serial clock
  input wire logic       cs_n_i,        // Select
  input wire logic [3:0] io_i,          // Pin levels
  input wire logic [3:0] io_o,          // Drive values
  input wire logic [3:0] io_oe_o,       // Drive enables
  input wire logic [7:0] opcode_o,      // Opcode
  input wire logic       array_cmd_o,   // Array pulse
  input wire logic       load_strobe_o, // Load pulse
  input wire logic       write_latch_o, // Latch
  input wire logic       quad_enable_o, // Quad enable
  input wire logic       paused_o,      // Pause
  input wire logic       reject_o       // Refusal pulse
);
  logic [3:0] since_fall;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ====================
  // Cycles since serial clock fall
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || $fell(sclk_i)) since_fall <= 4'h0;
    else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
  end
  sequence hold_fall_s;
    $fell(io_i[3]) && !cs_n_i && !sclk_i && !quad_enable_o;
  endsequence
  sequence hold_low_s;
    (!cs_n_i && !sclk_i && !io_i[3])[*7];
  endsequence
  sequence hold_rise_s;
    $rose(io_i[3]) && !cs_n_i && !sclk_i;
  endsequence
  sequence hold_high_s;
    (!cs_n_i && !sclk_i && io_i[3])[*7];
  endsequence
  desel_float_a: assert property (cs_n_i[*6] |-> io_oe_o == 4'h0)
    else $error("pins driven while deselected");
  out_after_fall_a: assert property ($changed(io_o) && io_oe_o != 4'h0 && !cs_n_i |->
    since_fall inside {[1:7]}) else $error("output changed away from clock fall");
  pause_start_a: assert property (hold_fall_s ##0 hold_low_s |-> paused_o)
    else $error("pause did not begin");
  pause_end_a: assert property (hold_rise_s ##0 hold_high_s |-> !paused_o)
    else $error("pause did not end");
  pause_float_a: assert property (paused_o[*5] |-> io_oe_o == 4'h0 && $stable(opcode_o))
    else $error("activity while paused");
  quad_no_pause_a: assert property (quad_enable_o |-> !paused_o)
    else $error("pause under quad enable");
  quad_reject_a: assert property (reject_o |-> !quad_enable_o)
    else $error("quad command refused with quad enable");
  latch_set_a: assert property ($rose(write_latch_o) |-> opcode_o == `SNFE_OP_WREN)
    else $error("latch set by other opcode");
  array_op_a: assert property (array_cmd_o |-> opcode_o inside {8'h13, 8'h10, 8'hD8})
    else $error("array pulse for other opcode");
  desel_abort_a: assert property (cs_n_i[*6] |-> !array_cmd_o && !load_strobe_o && !reject_o && !paused_o)
    else $error("activity after deselect");
endmodule // snfe_front_end_props
bind snfe_front_end snfe_front_end_props u_snfe_front_end_props (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .io_i(io_i),
  .io_o(io_o), .io_oe_o(io_oe_o), .opcode_o(opcode_o), .array_cmd_o(array_cmd_o),
  .load_strobe_o(load_strobe_o), .write_latch_o(write_latch_o), .quad_enable_o(quad_enable_o),
  .paused_o(paused_o), .reject_o(reject_o)
);
`default_nettype wire

// *** tb/snfe_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module snfe_host (
  input  wire logic       mclk_i,   // Clock
  input  wire logic [3:0] dev_d_i,  // Device values
  input  wire logic [3:0] dev_oe_i, // Device enables
  output logic            sclk_o,   // Serial clock
  output logic            cs_n_o,   // Select
  output logic [3:0]      io_o      // Pin levels
);
  logic [3:0] hd = 4'hC;
  logic [3:0] hoe = 4'hD;
  logic       hold_n = 1'b1;
  logic       wp_n = 1'b1;
  logic       tog = 1'b0;
  int         half = 10;
  initial sclk_o = 1'b0;
  initial cs_n_o = 1'b0;
  always @(posedge mclk_i) tog <= ~tog;
  // ====================
  // Pin levels, floating lines toggle
  always_comb for (int b = 0; b < 4; b++) io_o[b] = dev_oe_i[b] ? dev_d_i[b] : hoe[b] ? hd[b] : tog;
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic sel(input logic v);
    @(posedge mclk_i);
    cs_n_o <= ~v;
    wt(half);
  endtask
  task automatic pins(input logic h, input logic p);
    @(posedge mclk_i);
    hold_n <= h;
    wp_n <= p;
    hd[3:2] <= {h, p};
    wt(half);
  endtask
  task automatic xfer(input logic [31:0] d, input int nb, input int w, input logic rd, output logic [31:0] q);
    q = 32'h0;
    for (int i = nb - w; i >= 0; i -= w) begin
      @(posedge mclk_i);
      hd <= (w == 4) ? d[i +: 4] : (w == 2) ? {hold_n, wp_n, d[i +: 2]} : {hold_n, wp_n, 1'b0, d[i]};
      hoe <= rd ? ((w == 4) ? 4'h0 : 4'hC) : ((w == 1) ? 4'hD : 4'hF);
      wt(half);
      sclk_o <= 1'b1;
      q = (q << w) | ((w == 4) ? io_o : (w == 2) ? io_o[1:0] : io_o[1]);
      wt(half);
      sclk_o <= 1'b0;
    end
  endtask
endmodule // snfe_host
`default_nettype wire

// *** tb/tb_snfe_front_end.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "snfe_defines.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_snfe_front_end;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sclk, cs_n, arr, lds, wl, qe, pa, rej;
  logic [3:0]  io_w, io_d, io_oe;
  logic [7:0]  status = 8'hC1;
  logic [7:0]  cdata = 8'h00;
  logic [11:0] col;
  logic [7:0]  opc, ld;
  logic [15:0] row;
  logic        arr_seen = 1'b0;
  logic        rej_seen = 1'b0;
  logic [7:0]  ld_last = 8'h00;
  logic [31:0] q;
  int          ld_cnt = 0;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #4 mclk_i = ~mclk_i;
  // ====================
  // Cache model and pulse catchers
  always @(posedge mclk_i) begin
    cdata <= col[7:0] + {col[11:8], 4'h0};
    if (arr) arr_seen <= 1'b1;
    if (rej) rej_seen <= 1'b1;
    if (lds) begin
      ld_cnt <= ld_cnt + 1;
      ld_last <= ld;
    end
  end
  snfe_host u_snfe_host (.mclk_i(mclk_i), .dev_d_i(io_d), .dev_oe_i(io_oe), .sclk_o(sclk), .cs_n_o(cs_n),
    .io_o(io_w));
  snfe_front_end u_snfe_front_end (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(io_w), .io_o(io_d), .io_oe_o(io_oe), .status_i(status), .cache_data_i(cdata), .cache_col_o(col),
    .opcode_o(opc), .row_addr_o(row), .array_cmd_o(arr), .load_data_o(ld), .load_strobe_o(lds),
    .write_latch_o(wl), .quad_enable_o(qe), .paused_o(pa), .reject_o(rej));
  task automatic tx(input logic [31:0] d, input int nb, input int w, input logic rd = 1'b0);
    u_snfe_host.xfer(d, nb, w, rd, q);
  endtask
  task automatic run(input logic [7:0] op, input logic [31:0] d, input int nb, input int w, input int rn,
                     input int rw);
    u_snfe_host.sel(1'b1);
    tx({24'h0, op}, 8, 1);
    tx(d, nb, w);
    if (rn > 0) tx(32'h0, rn, rw, 1'b1);
    u_snfe_host.sel(1'b0);
  endtask
  task automatic tend(input string s);
    $display("Test %s done", s);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk_i);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    tx({24'h0, `SNFE_OP_WREN}, 8, 1);
    `CHK(wl, 1'b0)
    u_snfe_host.sel(1'b0);
    u_snfe_host.sel(1'b1);
    tx(32'h0, 4, 1);
    u_snfe_host.pins(1'b0, 1'b1);
    `CHK(pa, 1'b1)
    tx(32'hF, 4, 1);
    `CHK(io_oe, 4'h0)
    u_snfe_host.pins(1'b1, 1'b1);
    `CHK(pa, 1'b0)
    tx(32'h6, 4, 1);
    u_snfe_host.sel(1'b0);
    `CHK(wl, 1'b1)
    run(`SNFE_OP_WRDI, 32'h0, 0, 1, 0, 1);
    `CHK(wl, 1'b0)
    u_snfe_host.sel(1'b1);
    tx(32'h0, 4, 1);
    u_snfe_host.sel(1'b0);
    run(`SNFE_OP_WREN, 32'h0, 0, 1, 0, 1);
    `CHK(wl, 1'b1)
    tend("latch");
    run(`SNFE_OP_GETF, {24'h0, `SNFE_FA_STAT}, 8, 1, 24, 1);
    `CHK(q[23:0], {3{8'hC3}})
    status <= 8'h3C;
    run(`SNFE_OP_GETF, {24'h0, `SNFE_FA_STAT}, 8, 1, 8, 1);
    `CHK(q[7:0], 8'h3E)
    u_snfe_host.half = 14;
    run(`SNFE_OP_RDID, 32'h0, 8, 1, 16, 1);
    `CHK(q[15:0], {`SNFE_MAKER_ID, `SNFE_PART_ID})
    u_snfe_host.half = 10;
    run(`SNFE_OP_RC4, 32'h0, 0, 1, 0, 1);
    `CHK(rej_seen, 1'b1)
    tend("status");
    run(`SNFE_OP_SETF, {16'h0, `SNFE_FA_LOCK, 8'hBE}, 16, 1, 0, 1);
    u_snfe_host.pins(1'b1, 1'b0);
    run(`SNFE_OP_SETF, {16'h0, `SNFE_FA_LOCK, 8'h80}, 16, 1, 0, 1);
    run(`SNFE_OP_GETF, {24'h0, `SNFE_FA_LOCK}, 8, 1, 8, 1);
    `CHK(q[7:0], 8'hBE)
    run(`SNFE_OP_SETF, {16'h0, `SNFE_FA_FEAT, 8'h01}, 16, 1, 0, 1);
    `CHK(qe, 1'b1)
    run(`SNFE_OP_SETF, {16'h0, `SNFE_FA_LOCK, 8'h00}, 16, 1, 0, 1);
    run(`SNFE_OP_GETF, {24'h0, `SNFE_FA_LOCK}, 8, 1, 8, 1);
    `CHK(q[7:0], 8'h00)
    u_snfe_host.sel(1'b1);
    u_snfe_host.pins(1'b0, 1'b0);
    `CHK(pa, 1'b0)
    u_snfe_host.pins(1'b1, 1'b0);
    u_snfe_host.sel(1'b0);
    tend("protect");
    run(`SNFE_OP_PRD, 32'h001234, 24, 1, 0, 1);
    `CHK(row, 16'h1234)
    `CHK(arr_seen, 1'b1)
    run(`SNFE_OP_RC1, 32'hF56700, 24, 1, 16, 1);
    `CHK(q[15:0], 16'hB7B8)
    run(`SNFE_OP_RCD, 32'hFA1200, 24, 2, 16, 2);
    `CHK(q[15:0], 16'hB2B3)
    run(`SNFE_OP_RCQ, 32'h734500, 24, 4, 16, 4);
    `CHK(q[15:0], 16'h7576)
    run(`SNFE_OP_PLRQ, 32'h9210A55A, 32, 4, 0, 1);
    `CHK(ld_cnt, 2)
    `CHK(ld_last, 8'h5A)
    run(`SNFE_OP_PE, 32'h005678, 24, 1, 0, 1);
    `CHK(row, 16'h5678)
    `CHK(opc, `SNFE_OP_PE)
    tend("cache");
    final_report;
  end
endmodule // tb_snfe_front_end
`default_nettype wire
